// ---- inc/dpr_pkg.sv ----
// Purpose: Shared constants and types of the dual-port memory block.
// Assumes: One system clock; port clocks are enable pulses from dividers.
// Notes: Register offsets are byte addresses on a 32-bit classic Wishbone bus.

package dpr_pkg;

  // ***************************************************************
  // Widths
  // ***************************************************************
  localparam int ADDR_W = 16;
  localparam int BE_W = 8;
  localparam int LANE_W = 9;
  localparam int DATA_W = 72;
  localparam int DIV_W = 8;
  localparam int SP_SPLIT_MAX_BITS = 2048;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_DIV = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SDP_BIT = 2;
  localparam int CTRL_BYP_A_BIT = 3;
  localparam int CTRL_BYP_B_BIT = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] DIV_RESET = 32'h0000_0000;

  // ***************************************************************
  // Register groups, each with its own enable pulse, enable and clear
  // ***************************************************************
  localparam logic [1:0] GRP_A_IN = 2'h0;
  localparam logic [1:0] GRP_A_OUT = 2'h1;
  localparam logic [1:0] GRP_B_IN = 2'h2;
  localparam logic [1:0] GRP_B_OUT = 2'h3;

  typedef enum logic [1:0] {
    MODE_IND = 2'b00,
    MODE_IO = 2'b01,
    MODE_RW = 2'b10,
    MODE_SP = 2'b11
  } dpr_mode_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0] be;
    logic wren;
    logic [DATA_W-1:0] din;
  } dpr_req_type;

  typedef struct packed {
    logic ce;
    logic clr;
  } dpr_ctl_type;

endpackage

// ---- verilog/dpr_div.sv ----
// Purpose: Divider making the enable pulse that stands in for one port clock.
// Assumes: Divisor is stable while in use.
// Notes: A divisor of N gives one pulse every N+1 cycles.
`timescale 1ns/10ps

module dpr_div #(
  parameter int W = 8 // Divisor width.
) (
  input wire logic i_clk_sys, // System clock.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic [W-1:0] i_div, // Cycles between pulses, minus one.
  output logic o_tick // One-cycle enable pulse.
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      o_tick <= 1'h0;
    end else if (cnt_q >= i_div) begin
      cnt_q <= '0;
      o_tick <= 1'h1;
    end else begin
      cnt_q <= cnt_q + W'(1);
      o_tick <= 1'h0;
    end
  end

endmodule

// ---- verilog/dpr_mem.sv ----
// Purpose: Two-port byte-lane memory array with registered read data.
// Assumes: Addresses and strobes come from the port input registers.
// Notes: When both ports write one byte in the same cycle, port B wins.
`timescale 1ns/10ps

module dpr_mem #(
  parameter int AW = 13, // Word address width.
  parameter int NL = 8, // Byte lanes.
  parameter int LW = 9 // Bits per lane.
) (
  input wire logic i_clk_sys, // System clock.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic [1:0] i_we, // Write strobe per port.
  input wire logic [1:0] i_re, // Read strobe per port.
  input wire logic [1:0] i_clr, // Read register clear per port.
  input wire logic [1:0][AW-1:0] i_addr, // Word address per port.
  input wire logic [1:0][NL-1:0] i_be, // Byte enables per port.
  input wire logic [1:0][NL*LW-1:0] i_wdata, // Write data per port.
  output logic [1:0][NL*LW-1:0] o_rdata, // Registered read data per port.
  output logic [1:0] o_valid // Read data was loaded last cycle.
);

  genvar l, p;

  generate
    for (l = 0; l < NL; l++) begin : g_lane
      logic [LW-1:0] arr [2**AW];

      always_ff @(posedge i_clk_sys) begin
        if (i_we[0] && i_be[0][l]) begin
          arr[i_addr[0]] <= i_wdata[0][l*LW +: LW];
        end
        if (i_we[1] && i_be[1][l]) begin
          arr[i_addr[1]] <= i_wdata[1][l*LW +: LW];
        end
      end

      for (p = 0; p < 2; p++) begin : g_port
        logic [LW-1:0] rd_q;

        always_ff @(posedge i_clk_sys) begin
          if (!i_rst_n || i_clr[p]) begin
            rd_q <= '0;
          end else if (i_re[p]) begin
            rd_q <= arr[i_addr[p]];
          end
        end

        assign o_rdata[p][l*LW +: LW] = rd_q;
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_valid <= '0;
    end else begin
      o_valid <= i_re & ~i_clr;
    end
  end

endmodule

// ---- verilog/dpr_top.sv ----
// Purpose: Dual-port block memory with four selectable port clocking modes.
// Assumes: Port clocks are enable pulses of dividers on the one system clock.
// Notes: Port clears act at the next system edge, whatever the port pulse.
//
// How it works
// - Each port takes address, byte enables, wren, data.
// - Independent mode: each port has own clock.
// - Independent mode: per-port enable and clear.
// - Every register is clearable in independent mode.
// - Input/output mode works true or simple dual-port.
// - Input/output mode: input clock, separate output clock.
// - Input and output groups: own enables, clears.
// - Simple dual-port read enable register never cleared.
// - Read/write mode: write clock, read clock split.
// - Two clocks, own enables, write/read side clears.
// - Single-port mode; split only at 2K bits each.
// - Write enable alone selects read or write.
// - Only enabled bytes are written.
// - Read output register can be bypassed.
`timescale 1ns/10ps

module dpr_top #(
  parameter int MEM_AW = 13, // Words held are 2**MEM_AW.
  parameter bit SP_DUAL = 1'h0 // Single-port mode hosts two memories.
) (
  input wire logic i_clk_sys, // System clock, 25 MHz.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic i_wb_cyc, // Wishbone cycle.
  input wire logic i_wb_stb, // Wishbone strobe.
  input wire logic i_wb_we, // Wishbone write.
  input wire logic [3:0] i_wb_adr, // Wishbone byte address.
  input wire logic [3:0] i_wb_sel, // Wishbone byte selects.
  input wire logic [31:0] i_wb_dat, // Wishbone write data.
  input wire dpr_pkg::dpr_req_type [1:0] i_port_req, // Requests, 0 is A, 1 is B.
  input wire logic i_b_rden, // Port B read enable, simple dual-port.
  input wire dpr_pkg::dpr_ctl_type [3:0] i_grp_ctl, // Enable and clear per group.
  output logic [31:0] o_wb_dat, // Wishbone read data.
  output logic o_wb_ack, // Wishbone acknowledge.
  output logic [1:0][dpr_pkg::DATA_W-1:0] o_port_dout // Read data, 0 is A.
);

  // ***************************************************************
  // Parameter checks
  // ***************************************************************
  generate
    if (MEM_AW < 2 || MEM_AW > dpr_pkg::ADDR_W) begin : g_bad_aw
      $error("MEM_AW out of range");
    end
    if (dpr_pkg::DATA_W != dpr_pkg::BE_W * dpr_pkg::LANE_W) begin : g_bad_dw
      $error("Data width does not match byte lanes");
    end
    if (SP_DUAL && (2**(MEM_AW-1)) * dpr_pkg::DATA_W > dpr_pkg::SP_SPLIT_MAX_BITS) begin : g_bad_sp
      $error("Split single-port memories exceed 2K bits each");
    end
  endgenerate

  // ***************************************************************
  // Register bus
  // ***************************************************************
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] div_q;
  logic [31:0] div_d;
  logic [15:0] wr_cnt_q;
  logic [15:0] wr_cnt_d;
  logic [31:0] rd_mux;
  wire wb_req = i_wb_cyc & i_wb_stb;
  wire wb_wr = wb_req & i_wb_we & o_wb_ack;
  wire hit_ctrl = i_wb_adr == dpr_pkg::OFS_CTRL;
  wire hit_div = i_wb_adr == dpr_pkg::OFS_DIV;
  wire hit_stat = i_wb_adr == dpr_pkg::OFS_STAT;

  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_wbyte
      assign ctrl_d[8*k +: 8] = (wb_wr && hit_ctrl && i_wb_sel[k]) ?
                                i_wb_dat[8*k +: 8] : ctrl_q[8*k +: 8];
      assign div_d[8*k +: 8] = (wb_wr && hit_div && i_wb_sel[k]) ?
                               i_wb_dat[8*k +: 8] : div_q[8*k +: 8];
    end
  endgenerate

  assign rd_mux = hit_ctrl ? ctrl_q :
                  hit_div ? div_q :
                  hit_stat ? {16'h0000, wr_cnt_q} : 32'h0000_0000;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ctrl_q <= dpr_pkg::CTRL_RESET;
      div_q <= dpr_pkg::DIV_RESET;
      o_wb_ack <= 1'h0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      div_q <= div_d;
      o_wb_ack <= wb_req & ~o_wb_ack;
      if (wb_req && !o_wb_ack) begin
        o_wb_dat <= rd_mux;
      end
    end
  end

  // ***************************************************************
  // Clocking mode and group routing
  // ***************************************************************
  dpr_pkg::dpr_mode_type mode;
  assign mode = dpr_pkg::dpr_mode_type'(ctrl_q[dpr_pkg::CTRL_MODE_LSB +: 2]);

  wire is_io = mode == dpr_pkg::MODE_IO;
  wire is_rw = mode == dpr_pkg::MODE_RW;
  wire is_sp = mode == dpr_pkg::MODE_SP;
  wire sdp = is_rw | (is_io & ctrl_q[dpr_pkg::CTRL_SDP_BIT]);
  wire split = is_sp & SP_DUAL;

  logic [1:0][1:0] in_grp;
  logic [1:0][1:0] out_grp;
  assign in_grp[0] = dpr_pkg::GRP_A_IN;
  assign out_grp[0] = is_io ? dpr_pkg::GRP_A_OUT : dpr_pkg::GRP_A_IN;
  assign in_grp[1] = is_rw ? dpr_pkg::GRP_B_OUT : dpr_pkg::GRP_B_IN;
  assign out_grp[1] = (is_io | is_rw) ? dpr_pkg::GRP_B_OUT : dpr_pkg::GRP_B_IN;

  logic [1:0] port_en;
  logic [1:0] wr_ok;
  logic [1:0] rd_ok;
  logic [1:0] byp;
  logic rden_q;
  assign port_en = {~is_sp | SP_DUAL, 1'h1};
  assign wr_ok = {~sdp, 1'h1};
  assign rd_ok = {rden_q, 1'h0};
  assign byp = {ctrl_q[dpr_pkg::CTRL_BYP_B_BIT], ctrl_q[dpr_pkg::CTRL_BYP_A_BIT]};

  logic [3:0] tick;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_div
      dpr_div #(
        .W(dpr_pkg::DIV_W)
      ) u_div (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_div(div_q[dpr_pkg::DIV_W*g +: dpr_pkg::DIV_W]),
        .o_tick(tick[g])
      );
    end
  endgenerate

  // ***************************************************************
  // Port input and output registers
  // ***************************************************************
  logic [1:0] in_tick;
  logic [1:0] in_ce;
  logic [1:0] in_clr;
  logic [1:0] out_tick;
  logic [1:0] out_ce;
  logic [1:0] out_clr;
  logic [1:0] cap;
  logic [1:0] go_q;
  dpr_pkg::dpr_req_type [1:0] req_q;
  logic [1:0] mem_we;
  logic [1:0] mem_re;
  logic [1:0] mem_valid;
  logic [1:0][MEM_AW-1:0] mem_addr;
  logic [1:0][dpr_pkg::BE_W-1:0] mem_be;
  logic [1:0][dpr_pkg::DATA_W-1:0] mem_wdata;
  logic [1:0][dpr_pkg::DATA_W-1:0] mem_rdata;
  logic [1:0] out_load;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      assign in_tick[p] = tick[in_grp[p]];
      assign in_ce[p] = i_grp_ctl[in_grp[p]].ce;
      assign in_clr[p] = i_grp_ctl[in_grp[p]].clr;
      assign out_tick[p] = tick[out_grp[p]];
      assign out_ce[p] = i_grp_ctl[out_grp[p]].ce;
      assign out_clr[p] = i_grp_ctl[out_grp[p]].clr;
      assign cap[p] = in_tick[p] & in_ce[p] & ~in_clr[p] & port_en[p];

      // Address, strobes and data are taken only on the capture edge.
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || in_clr[p]) begin
          req_q[p] <= '0;
          go_q[p] <= 1'h0;
        end else begin
          go_q[p] <= cap[p];
          if (cap[p]) begin
            req_q[p] <= i_port_req[p];
          end
        end
      end

      assign mem_we[p] = go_q[p] & req_q[p].wren & ~in_clr[p] & wr_ok[p];
      assign mem_re[p] = go_q[p] & ~in_clr[p] &
                         (sdp ? rd_ok[p] : ~req_q[p].wren);
      assign mem_addr[p] = split ? {1'(p), req_q[p].addr[MEM_AW-2:0]} :
                                   req_q[p].addr[MEM_AW-1:0];
      assign mem_be[p] = req_q[p].be;
      assign mem_wdata[p] = req_q[p].din;
      assign out_load[p] = byp[p] ? mem_valid[p] : (out_tick[p] & out_ce[p]);

      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || out_clr[p]) begin
          o_port_dout[p] <= '0;
        end else if (out_load[p]) begin
          o_port_dout[p] <= mem_rdata[p];
        end
      end
    end
  endgenerate

  // The read enable register ignores the read-side clear on purpose.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rden_q <= 1'h0;
    end else if (in_tick[1] && in_ce[1] && port_en[1]) begin
      rden_q <= i_b_rden;
    end
  end

  assign wr_cnt_d = wr_cnt_q + 16'(mem_we[0]) + 16'(mem_we[1]);

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      wr_cnt_q <= 16'h0000;
    end else begin
      wr_cnt_q <= wr_cnt_d;
    end
  end

  dpr_mem #(
    .AW(MEM_AW),
    .NL(dpr_pkg::BE_W),
    .LW(dpr_pkg::LANE_W)
  ) u_mem (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_we(mem_we),
    .i_re(mem_re),
    .i_clr(out_clr),
    .i_addr(mem_addr),
    .i_be(mem_be),
    .i_wdata(mem_wdata),
    .o_rdata(mem_rdata),
    .o_valid(mem_valid)
  );

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_bus_req;
    wb_req && !o_wb_ack;
  endsequence

  sequence s_read_a;
    (cap[0] && !i_port_req[0].wren && !sdp) ##1 (!in_clr[0] && !sdp && !out_clr[0]);
  endsequence

  AST_WB_ACK: assert property (s_bus_req |=> o_wb_ack ##1 !o_wb_ack)
    else $error("Bus acknowledge not a single cycle after request");
  AST_A_CAPTURE: assert property (cap[0] |=> go_q[0] && req_q[0] == $past(i_port_req[0]))
    else $error("Port A request not captured on its clock");
  AST_IN_CLEAR: assert property (in_clr[1] |=> !go_q[1] && req_q[1] == '0)
    else $error("Port B input clear did not empty its registers");
  AST_OUT_CLEAR: assert property (out_clr[0] |=> o_port_dout[0] == '0)
    else $error("Port A output clear did not zero read data");
  AST_IO_OUT_HOLD: assert property (is_io && !byp[0] && !out_clr[0] &&
      !(tick[dpr_pkg::GRP_A_OUT] && i_grp_ctl[dpr_pkg::GRP_A_OUT].ce) |=> $stable(o_port_dout[0]))
    else $error("Port A output moved without its output clock");
  AST_IO_SEP_CLR: assert property (is_io && i_grp_ctl[dpr_pkg::GRP_A_OUT].clr && cap[0]
      |=> go_q[0])
    else $error("Output clear disturbed the input registers");
  AST_RDEN_NO_CLR: assert property (in_clr[1] && in_tick[1] && in_ce[1] && port_en[1]
      |=> rden_q == $past(i_b_rden))
    else $error("Read enable register was cleared");
  AST_SDP_B_NO_WRITE: assert property (sdp |-> !mem_we[1])
    else $error("Port B wrote in simple dual-port use");
  AST_SP_B_IDLE: assert property ((is_sp && !SP_DUAL) [*2] |-> !go_q[1] && !mem_we[1])
    else $error("Port B active in single-port mode");
  AST_READ_A: assert property (s_read_a |=> mem_valid[0])
    else $error("Port A read with write enable low gave no data");
  AST_BYPASS_A: assert property (byp[0] && mem_valid[0] && !out_clr[0]
      |=> o_port_dout[0] == $past(mem_rdata[0]))
    else $error("Bypassed output did not follow the array");
  AST_WRITE_GATE: assert property (mem_we[0] |-> $past(cap[0]) && !in_clr[0])
    else $error("Port A write without an enabled input edge");

endmodule

// ---- dv/dpr_user_model.sv ----
// Purpose: Fabric logic that drives the memory ports and group controls.
// Assumes: Calls come from the bench just after a rising clock edge.
// Notes: A port that stops writing keeps its address but inverts its data.
`timescale 1ns/10ps

module dpr_user_model (
  input wire logic i_clk_sys, // System clock.
  output dpr_pkg::dpr_req_type [1:0] o_req, // Port requests.
  output dpr_pkg::dpr_ctl_type [3:0] o_ctl, // Group enables and clears.
  output logic o_rden // Port B read enable.
);
  initial begin
    o_req = '0;
    o_ctl = {4{2'h2}};
    o_rden = 1'h0;
  end

  // ***************************************************************
  // Requests
  // ***************************************************************
  task automatic put(input int p, input logic [15:0] a, input logic [7:0] be,
                     input logic we, input logic [71:0] d);
    @(posedge i_clk_sys);
    o_req[p] <= '{addr: a, be: be, wren: we, din: d};
  endtask

  // A write is followed by reads of the same word, address held.
  task automatic xfer(input int p, input logic [15:0] a, input logic [7:0] be,
                      input logic [71:0] d);
    put(p, a, be, 1'h1, d);
    put(p, a, be, 1'h0, ~d);
  endtask

  task automatic ctl(input int g, input logic ce, input logic clr);
    @(posedge i_clk_sys);
    o_ctl[g] <= '{ce: ce, clr: clr};
  endtask

  task automatic rden(input logic v);
    @(posedge i_clk_sys);
    o_rden <= v;
  endtask
endmodule

// ---- dv/tb.sv ----
// Purpose: Self-checking bench of the dual-port memory block.
// Assumes: All divisors stay zero, so every group pulses each cycle.
// Notes: Register bus and ports are driven on the rising edge.
`timescale 1ns/10ps

module tb;
  logic i_clk_sys = 1'h0;
  logic i_rst_n = 1'h0;
  logic wb_cyc = 1'h0;
  logic wb_stb = 1'h0;
  logic wb_we = 1'h0;
  logic [3:0] wb_adr = 4'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wd = 32'h0000_0000;
  logic [31:0] wb_rd;
  logic o_wb_ack;
  logic [1:0][71:0] dout;
  dpr_pkg::dpr_req_type [1:0] req;
  dpr_pkg::dpr_ctl_type [3:0] ctl;
  logic b_rden;
  int n_fail = 0;
  int checks_done = 0;

  always #20 i_clk_sys = ~i_clk_sys;

  dpr_user_model u_user (.i_clk_sys(i_clk_sys), .o_req(req), .o_ctl(ctl), .o_rden(b_rden));

  dpr_top DUT (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
    .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_wd),
    .i_port_req(req), .i_b_rden(b_rden), .i_grp_ctl(ctl), .o_wb_dat(wb_rd),
    .o_wb_ack(o_wb_ack), .o_port_dout(dout)
  );

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                    output logic [71:0] rd);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wd <= wd;
    wb_sel <= 4'hf;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_wb_ack !== 1'h1 && n < 20);
    rd = {40'h00_0000_0000, wb_rd};
    if (n >= 20) n_fail++;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    wb_we <= 1'h0;
    @(posedge i_clk_sys);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_regs;
    logic [71:0] rd;
    wb(1'h0, 4'h0, 32'h0, rd);
    chk(rd, 72'h0);
    wb(1'h0, 4'h4, 32'h0, rd);
    chk(rd, 72'h0);
    wb(1'h1, 4'hc, 32'hffff_ffff, rd);
    wb(1'h0, 4'hc, 32'h0, rd);
    chk(rd, 72'h0);
  endtask

  task automatic t_wr_rd;
    logic [71:0] rd;
    wb(1'h1, 4'h0, 32'h0000_0018, rd);
    u_user.put(1, 16'h0005, 8'hff, 1'h0, 72'h0);
    u_user.xfer(0, 16'h0005, 8'hff, 72'hff_ffff_ffff_ffff_ffff);
    settle(4);
    chk(dout[0], 72'hff_ffff_ffff_ffff_ffff);
    chk(dout[1], 72'hff_ffff_ffff_ffff_ffff);
    u_user.xfer(0, 16'h0005, 8'h0f, 72'h0);
    settle(4);
    chk(dout[0], 72'hff_ffff_fff0_0000_0000);
    chk(dout[1], 72'hff_ffff_fff0_0000_0000);
    wb(1'h0, 4'h8, 32'h0, rd);
    chk(rd, 72'h2);
  endtask

  task automatic t_ce_clr;
    u_user.ctl(0, 1'h0, 1'h0);
    u_user.xfer(0, 16'h0005, 8'hff, 72'h12_3456_789a_bcde_f012);
    u_user.ctl(0, 1'h1, 1'h0);
    settle(4);
    chk(dout[0], 72'hff_ffff_fff0_0000_0000);
    u_user.ctl(0, 1'h1, 1'h1);
    settle(2);
    chk(dout[0], 72'h0);
    chk(dout[1], 72'hff_ffff_fff0_0000_0000);
    u_user.ctl(0, 1'h1, 1'h0);
    settle(4);
    chk(dout[0], 72'hff_ffff_fff0_0000_0000);
  endtask

  task automatic t_rw;
    logic [71:0] rd;
    wb(1'h1, 4'h0, 32'h0000_0002, rd);
    u_user.xfer(0, 16'h0009, 8'hff, 72'hab_cdef_0123_4567_89ab);
    u_user.rden(1'h1);
    u_user.put(1, 16'h0009, 8'hff, 1'h1, 72'h11_1111_1111_1111_1111);
    settle(5);
    chk(dout[1], 72'hab_cdef_0123_4567_89ab);
    wb(1'h0, 4'h0, 32'h0, rd);
    chk(rd, 72'h2);
    u_user.ctl(3, 1'h1, 1'h1);
    settle(2);
    chk(dout[1], 72'h0);
    u_user.ctl(3, 1'h1, 1'h0);
    settle(4);
    chk(dout[1], 72'hab_cdef_0123_4567_89ab);
  endtask

  // Port B keeps writing word 9 in true dual use; single-port mode reads it back.
  task automatic t_io;
    logic [71:0] rd;
    wb(1'h1, 4'h0, 32'h0000_0001, rd);
    u_user.xfer(0, 16'h0020, 8'hff, 72'h5a_5a5a_5a5a_5a5a_5a5a);
    settle(4);
    chk(dout[0], 72'h5a_5a5a_5a5a_5a5a_5a5a);
    u_user.ctl(1, 1'h0, 1'h0);
    u_user.xfer(0, 16'h0020, 8'hff, 72'ha5_a5a5_a5a5_a5a5_a5a5);
    settle(4);
    chk(dout[0], 72'h5a_5a5a_5a5a_5a5a_5a5a);
    u_user.ctl(1, 1'h1, 1'h0);
    settle(2);
    chk(dout[0], 72'ha5_a5a5_a5a5_a5a5_a5a5);
    u_user.ctl(1, 1'h1, 1'h1);
    u_user.xfer(0, 16'h0021, 8'hff, 72'h3c_3c3c_3c3c_3c3c_3c3c);
    settle(3);
    chk(dout[0], 72'h0);
    u_user.ctl(1, 1'h1, 1'h0);
    settle(3);
    chk(dout[0], 72'h3c_3c3c_3c3c_3c3c_3c3c);
  endtask

  task automatic t_sp;
    logic [71:0] rd;
    wb(1'h1, 4'h0, 32'h0000_0003, rd);
    u_user.put(1, 16'h0021, 8'hff, 1'h1, 72'h0);
    u_user.put(0, 16'h0009, 8'hff, 1'h0, 72'h0);
    settle(4);
    chk(dout[0], 72'h11_1111_1111_1111_1111);
    u_user.put(0, 16'h0021, 8'hff, 1'h0, 72'h0);
    settle(4);
    chk(dout[0], 72'h3c_3c3c_3c3c_3c3c_3c3c);
  endtask

  // ***************************************************************
  // Run control
  // ***************************************************************
  task automatic results;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_rst_n <= 1'h1;
    t_regs();
    t_wr_rd();
    t_ce_clr();
    t_rw();
    t_io();
    t_sp();
    results();
  end

  initial begin
    repeat (3000) @(posedge i_clk_sys);
    n_fail++;
    results();
  end
endmodule
